// *** core/analog_comparator_control.sv ***
// Top of the two-channel comparator control block with its AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module analog_comparator_control
  import cmp_pkg::*;
#(
  parameter int INSTR_DIV = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] analog_raw,
  input wire logic tmr_clk,
  input wire logic [1:0] pin_direction,
  input wire logic [1:0] port_latch,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] gate_src,
  output logic [1:0] shutdown_src,
  output logic [1:0] cmp_irq_flag,
  output logic [3:0] pos_route_1,
  output logic [3:0] pos_route_2,
  output logic [3:0] neg_route_1,
  output logic [3:0] neg_route_2,
  output logic [1:0] hyst_ctrl,
  output logic [1:0] speed_ctrl,
  output logic [1:0] analog_select
);
  ////////////////////////////////////////////////////////////////////////////
  // Instruction-cycle tick and timer clock falling edge
  logic [7:0] div_reg, div_next;
  logic tick;
  logic tclk_reg, tclk_next;
  logic tmr_fall;

  always_comb begin
    tick = (div_reg == 8'(INSTR_DIV - 1));
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    tclk_next = tmr_clk;
    tmr_fall = tclk_reg & ~tmr_clk;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 8'h00;
      tclk_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tclk_reg <= tclk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] first_reg [CH_COUNT];
  logic [7:0] second_reg [CH_COUNT];
  logic [7:0] first_next [CH_COUNT];
  logic [7:0] second_next [CH_COUNT];
  logic [1:0] analog_reg, analog_next;
  logic [1:0] result_bits, flag_bits, pin_res, gate_res, clr;
  logic [3:0] pos_r [CH_COUNT];
  logic [3:0] neg_r [CH_COUNT];

  // Write channel state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic do_write, write_hit;
  // Read channel state
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] rd_val;
  logic rd_hit;

  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    do_write = aw_hold_reg & w_hold_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    analog_next = analog_reg;
    clr = 2'b00;
    write_hit = 1'b0;
    for (int c = 0; c < CH_COUNT; c++) begin
      first_next[c] = first_reg[c];
      second_next[c] = second_reg[c];
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      for (int c = 0; c < CH_COUNT; c++) begin
        if (awaddr_reg == ADDR_CTRL_FIRST_1 + 8'(c) * CH_STRIDE) begin
          write_hit = 1'b1;
          if (wstrb_reg[0]) begin
            first_next[c] = wdata_reg[7:0] & FIRST_WMASK;
          end
        end
        if (awaddr_reg == ADDR_CTRL_SECOND_1 + 8'(c) * CH_STRIDE) begin
          write_hit = 1'b1;
          if (wstrb_reg[0]) begin
            second_next[c] = wdata_reg[7:0] & SECOND_WMASK;
          end
        end
      end
      if (awaddr_reg == ADDR_IRQ_FLAGS) begin
        write_hit = 1'b1;
        // Write one to clear; a simultaneous enabled edge keeps the flag
        clr = wstrb_reg[0] ? wdata_reg[1:0] : 2'b00;
      end
      if (awaddr_reg == ADDR_ANALOG) begin
        write_hit = 1'b1;
        if (wstrb_reg[0]) begin
          analog_next = wdata_reg[1:0];
        end
      end
      if (awaddr_reg == ADDR_MIRROR) begin
        write_hit = 1'b1;
      end
      bresp_next = write_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL_FIRST_1: rd_val = first_reg[0] | {1'b0, result_bits[0], 6'h00};
      ADDR_CTRL_FIRST_2: rd_val = first_reg[1] | {1'b0, result_bits[1], 6'h00};
      ADDR_CTRL_SECOND_1: rd_val = second_reg[0];
      ADDR_CTRL_SECOND_2: rd_val = second_reg[1];
      ADDR_MIRROR: rd_val = {6'h00, result_bits};
      ADDR_IRQ_FLAGS: rd_val = {6'h00, flag_bits};
      ADDR_ANALOG: rd_val = {6'h00, analog_reg};
      default: rd_hit = 1'b0;
    endcase
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_val};
      rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
      analog_reg <= 2'b00;
      for (int c = 0; c < CH_COUNT; c++) begin
        first_reg[c] <= FIRST_RESET;
        second_reg[c] <= SECOND_RESET;
      end
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      analog_reg <= analog_next;
      for (int c = 0; c < CH_COUNT; c++) begin
        first_reg[c] <= first_next[c];
        second_reg[c] <= second_next[c];
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign analog_select = analog_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar g = 0; g < CH_COUNT; g++) begin : gen_ch
    cmp_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .instr_tick(tick),
      .tmr_clk_fall(tmr_fall),
      .analog_raw(analog_raw[g]),
      .ctrl_first(first_reg[g]),
      .ctrl_second(second_reg[g]),
      .flag_clear(clr[g]),
      .result_reg(result_bits[g]),
      .pin_result(pin_res[g]),
      .gate_result(gate_res[g]),
      .flag_reg(flag_bits[g]),
      .pos_route(pos_r[g]),
      .neg_route(neg_r[g]),
      .hyst_ctrl(hyst_ctrl[g]),
      .speed_ctrl(speed_ctrl[g])
    );
    // Override replaces the port latch regardless of the on bit
    assign pin_out[g] = first_reg[g][B_OE] ? pin_res[g] : port_latch[g];
    assign pin_oe[g] = ~pin_direction[g];
  end

  assign gate_src = gate_res;
  assign shutdown_src = result_bits;
  assign cmp_irq_flag = flag_bits;
  assign pos_route_1 = pos_r[0];
  assign pos_route_2 = pos_r[1];
  assign neg_route_1 = neg_r[0];
  assign neg_route_2 = neg_r[1];

  property p_mirror;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_MIRROR)
        |=> s_axi_rvalid && s_axi_rdata == {30'h0, $past(result_bits)};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror read wrong");
  property p_override;
    @(posedge aclk) disable iff (!aresetn)
      first_reg[0][B_OE] |-> pin_out[0] == pin_res[0];
  endproperty
  a_override: assert property (p_override) else $error("override missing");
  property p_sp_reset;
    @(posedge aclk) $fell(aresetn) |=> speed_ctrl == 2'b11;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("speed bit reset wrong");
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
endmodule : analog_comparator_control

// *** core/cmp_pkg.sv ***
// Package: register map, field layout and reset values of the comparator control block
package cmp_pkg;
  localparam int CH_COUNT = 2;
  localparam logic [7:0] ADDR_CTRL_FIRST_1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL_SECOND_1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL_FIRST_2 = 8'h08;
  localparam logic [7:0] ADDR_CTRL_SECOND_2 = 8'h0C;
  localparam logic [7:0] ADDR_MIRROR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_ANALOG = 8'h18;
  // Stride between the two channels' register pairs
  localparam logic [7:0] CH_STRIDE = 8'h08;
  // First control register bit positions
  localparam int B_ON = 7;
  localparam int B_RESULT = 6;
  localparam int B_OE = 5;
  localparam int B_INV = 4;
  localparam int B_SP = 2;
  localparam int B_HYS = 1;
  localparam int B_SYNC = 0;
  // Second control register bit positions
  localparam int B_RISE = 7;
  localparam int B_FALL = 6;
  localparam int B_PCH = 4;
  localparam int B_NCH = 0;
  localparam logic [7:0] FIRST_WMASK = 8'hB7;
  localparam logic [7:0] SECOND_WMASK = 8'hF3;
  localparam logic [7:0] FIRST_RESET = 8'h04;
  localparam logic [7:0] SECOND_RESET = 8'h00;
  localparam logic [1:0] PCH_PIN = 2'h0;
  localparam logic [1:0] PCH_DAC = 2'h1;
  localparam logic [1:0] PCH_FREF = 2'h2;
  localparam logic [1:0] PCH_GND = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmp_pkg

// *** core/cmp_channel.sv ***
// One comparator channel: polarity, sampling, sync, edge flag and input routing
`timescale 1ns/10ps
module cmp_channel
  import cmp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_tick,
  input wire logic tmr_clk_fall,
  input wire logic analog_raw,
  input wire logic [7:0] ctrl_first,
  input wire logic [7:0] ctrl_second,
  input wire logic flag_clear,
  output logic result_reg,
  output logic pin_result,
  output logic gate_result,
  output logic flag_reg,
  output logic [3:0] pos_route,
  output logic [3:0] neg_route,
  output logic hyst_ctrl,
  output logic speed_ctrl
);
  logic on, inv, sync_en;
  logic polar;
  logic result_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;
  logic flag_next;
  logic rise, fall;

  assign on = ctrl_first[B_ON];
  assign inv = ctrl_first[B_INV];
  assign sync_en = ctrl_first[B_SYNC];
  // Disabled comparator reads low before polarity, so on/off and invert can make edges
  assign polar = (analog_raw & on) ^ inv;

  always_comb begin
    result_next = instr_tick ? polar : result_reg;
    sync_next = tmr_clk_fall ? polar : sync_reg;
    prev_next = result_reg;
    rise = result_reg & ~prev_reg;
    fall = ~result_reg & prev_reg;
    flag_next = flag_reg;
    if (flag_clear) begin
      flag_next = 1'b0;
    end
    if ((rise & ctrl_second[B_RISE]) | (fall & ctrl_second[B_FALL])) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end

  // External path is unlatched unless timer sync is on
  assign pin_result = sync_en ? sync_reg : polar;
  assign gate_result = pin_result;
  assign pos_route = on ? (4'h1 << ctrl_second[B_PCH +: 2]) : 4'h0;
  assign neg_route = on ? (4'h1 << ctrl_second[B_NCH +: 2]) : 4'h0;
  assign hyst_ctrl = ctrl_first[B_HYS];
  assign speed_ctrl = ctrl_first[B_SP];

  property p_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (rise & ctrl_second[B_RISE] & flag_clear) |=> flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost on clear");
  property p_fall_sets;
    @(posedge aclk) disable iff (!aresetn)
      ($fell(result_reg) && ctrl_second[B_FALL]) |=> flag_reg;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall edge missed");
  property p_off_route;
    @(posedge aclk) disable iff (!aresetn) !on |-> (pos_route == 4'h0 && neg_route == 4'h0);
  endproperty
  a_off_route: assert property (p_off_route) else $error("inputs live while off");
  property p_sample;
    @(posedge aclk) disable iff (!aresetn) instr_tick |=> result_reg == $past(polar);
  endproperty
  a_sample: assert property (p_sample) else $error("result not sampled");
  property p_sync_hold;
    @(posedge aclk) disable iff (!aresetn)
      (sync_en && !tmr_clk_fall) ##1 sync_en |-> $stable(pin_result);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync out moved");
  c_flag: cover property (@(posedge aclk) disable iff (!aresetn) $rose(flag_reg));
  c_sync: cover property (@(posedge aclk) disable iff (!aresetn) sync_en && tmr_clk_fall);
endmodule : cmp_channel

// *** test/cmp_inputs_model.sv ***
// Far-side model: analog comparison levels and the prescaled gate timer clock
`timescale 1ns/10ps
module cmp_inputs_model (
  input wire logic aclk,
  input wire logic [1:0] level,
  input wire logic tmr_run,
  output logic [1:0] analog_raw,
  output logic tmr_clk
);
  logic [2:0] div_reg;
  initial begin
    div_reg = 3'h0;
    tmr_clk = 1'b0;
    analog_raw = 2'h0;
  end
  // Timer clock stands still unless the bench lets it run
  always @(posedge aclk) begin
    analog_raw <= level;
    div_reg <= div_reg + 3'h1;
    if (tmr_run && div_reg == 3'h7) begin
      tmr_clk <= ~tmr_clk;
    end
  end
endmodule : cmp_inputs_model

// *** test/tb_analog_comparator_control.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module tb_analog_comparator_control;
  import cmp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp_val;
  logic [1:0] level = 2'h0, pin_direction = 2'h0, port_latch = 2'h0;
  logic tmr_run = 1'b0, tmr_clk;
  logic [1:0] analog_raw, pin_out, pin_oe, gate_src, shutdown_src, cmp_irq_flag;
  logic [1:0] hyst_ctrl, speed_ctrl, analog_select;
  logic [3:0] pos_route_1, pos_route_2, neg_route_1, neg_route_2;
  int fail_count = 0, samples_checked = 0;

  always #12.5 aclk = ~aclk;

  analog_comparator_control #(.INSTR_DIV(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .analog_raw(analog_raw), .tmr_clk(tmr_clk), .pin_direction(pin_direction),
    .port_latch(port_latch), .pin_out(pin_out), .pin_oe(pin_oe), .gate_src(gate_src),
    .shutdown_src(shutdown_src), .cmp_irq_flag(cmp_irq_flag), .pos_route_1(pos_route_1),
    .pos_route_2(pos_route_2), .neg_route_1(neg_route_1), .neg_route_2(neg_route_2),
    .hyst_ctrl(hyst_ctrl), .speed_ctrl(speed_ctrl), .analog_select(analog_select));

  cmp_inputs_model partner (.aclk(aclk), .level(level), .tmr_run(tmr_run),
    .analog_raw(analog_raw), .tmr_clk(tmr_clk));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Ready is looked at mid-cycle, where it has settled; release happens at the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ok_a, ok_w, ok_b;
    ta = 1'b0;
    tw = 1'b0;
    ok_b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ok_a = awvalid && awready;
      ok_w = wvalid && wready;
      @(posedge aclk);
      if (ok_a) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (ok_w) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end
    while (!ok_b) begin
      @(negedge aclk);
      ok_b = bvalid;
      @(posedge aclk);
    end
    rsp_val = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok) begin
      @(negedge aclk);
      ok = arvalid && arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ok = rvalid;
      @(posedge aclk);
    end
    rd_val = rdata;
    rsp_val = rresp;
    rready <= 1'b0;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_and_map;
    rd(ADDR_CTRL_FIRST_1);
    chk("first1 reset", rd_val, 32'h00000004);
    chk("read okay", rsp_val, RESP_OKAY);
    chk("speed reset", speed_ctrl, 2'h3);
    rd(8'h1C);
    chk("unmapped read", rsp_val, RESP_SLVERR);
    wr(8'h1C, 32'h000000FF);
    chk("unmapped write", rsp_val, RESP_SLVERR);
    wr(ADDR_MIRROR, 32'h000000FF);
    chk("mirror write", rsp_val, RESP_OKAY);
    wr(ADDR_CTRL_FIRST_1, 32'h00000002);
    chk("speed low", speed_ctrl, 2'h2);
    chk("hyst on", hyst_ctrl, 2'h1);
    rd(ADDR_CTRL_FIRST_1);
    chk("first1 back", rd_val, 32'h00000002);
  endtask : reset_and_map

  task automatic result_mirror;
    level <= 2'h3;
    wr(ADDR_CTRL_FIRST_1, 32'h00000084);
    wr(ADDR_CTRL_FIRST_2, 32'h00000094);
    cyc(12);
    rd(ADDR_CTRL_FIRST_1);
    chk("result plain", rd_val, 32'h000000C4);
    rd(ADDR_MIRROR);
    chk("mirror", rd_val, 32'h00000001);
    wr(ADDR_CTRL_FIRST_2, 32'h00000084);
    wr(ADDR_CTRL_FIRST_1, 32'h00000094);
    cyc(12);
    rd(ADDR_MIRROR);
    chk("mirror swap", rd_val, 32'h00000002);
    chk("shutdown", shutdown_src, 2'h2);
  endtask : result_mirror

  task automatic pin_override;
    level <= 2'h0;
    port_latch <= 2'h1;
    wr(ADDR_CTRL_FIRST_1, 32'h000000A4);
    cyc(12);
    chk("pin result", pin_out[0], 1'b0);
    chk("pin drive", pin_oe[0], 1'b1);
    pin_direction <= 2'h1;
    cyc(2);
    chk("pin input", pin_oe[0], 1'b0);
    wr(ADDR_CTRL_FIRST_1, 32'h00000084);
    chk("pin latch", pin_out[0], 1'b1);
    port_latch <= 2'h0;
    wr(ADDR_CTRL_FIRST_1, 32'h00000030);
    cyc(12);
    chk("pin off inv", pin_out[0], 1'b1);
    pin_direction <= 2'h0;
  endtask : pin_override

  task automatic input_routes;
    wr(ADDR_CTRL_FIRST_1, 32'h00000084);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL_SECOND_1, {26'h0, c[1:0], 2'h0, c[1:0]});
      chk("pos route", pos_route_1, 4'h1 << c);
      chk("neg route", neg_route_1, 4'h1 << c);
    end
    rd(ADDR_CTRL_SECOND_1);
    chk("second back", rd_val, 32'h00000033);
    chk("ch2 routes", {pos_route_2, neg_route_2}, 8'h11);
    pin_direction <= 2'h3;
    wr(ADDR_ANALOG, 32'h00000003);
    chk("analog select", analog_select, 2'h3);
    chk("pins as inputs", pin_oe, 2'h0);
    rd(ADDR_ANALOG);
    chk("analog back", rd_val, 32'h00000003);
    pin_direction <= 2'h0;
    wr(ADDR_CTRL_FIRST_1, 32'h00000004);
    chk("off routes", {pos_route_1, neg_route_1}, 8'h00);
  endtask : input_routes

  task automatic edge_flags;
    wr(ADDR_CTRL_SECOND_1, 32'h00000080);
    cyc(12);
    wr(ADDR_IRQ_FLAGS, 32'h00000003);
    wr(ADDR_CTRL_FIRST_1, 32'h00000014);
    cyc(12);
    chk("rise flag", cmp_irq_flag, 2'h1);
    wr(ADDR_IRQ_FLAGS, 32'h00000001);
    chk("flag cleared", cmp_irq_flag, 2'h0);
    wr(ADDR_CTRL_FIRST_1, 32'h00000004);
    cyc(12);
    chk("fall ignored", cmp_irq_flag, 2'h0);
    wr(ADDR_CTRL_SECOND_1, 32'h00000040);
    wr(ADDR_CTRL_FIRST_1, 32'h00000014);
    wr(ADDR_CTRL_FIRST_1, 32'h00000004);
    cyc(12);
    rd(ADDR_IRQ_FLAGS);
    chk("fall flag", rd_val, 32'h00000001);
  endtask : edge_flags

  // Finds a sampling edge from the result, then lands a clear on the next rise
  task automatic set_wins;
    wr(ADDR_CTRL_SECOND_1, 32'h00000080);
    wr(ADDR_CTRL_FIRST_1, 32'h00000084);
    level <= 2'h1;
    cyc(12);
    wr(ADDR_IRQ_FLAGS, 32'h00000003);
    chk("flag armed", cmp_irq_flag, 2'h0);
    level <= 2'h0;
    while (shutdown_src[0] !== 1'b0) begin
      @(negedge aclk);
    end
    @(posedge aclk);
    level <= 2'h1;
    cyc(1);
    wr(ADDR_IRQ_FLAGS, 32'h00000001);
    chk("set wins", cmp_irq_flag[0], 1'b1);
    level <= 2'h0;
  endtask : set_wins

  task automatic timer_sync;
    wr(ADDR_CTRL_FIRST_2, 32'h00000085);
    wr(ADDR_CTRL_FIRST_1, 32'h00000084);
    tmr_run <= 1'b1;
    @(negedge tmr_clk);
    @(posedge aclk);
    level <= 2'h3;
    cyc(12);
    chk("async gate", gate_src[0], 1'b1);
    chk("sync held", gate_src[1], 1'b0);
    @(negedge tmr_clk);
    cyc(3);
    chk("sync taken", gate_src[1], 1'b1);
    tmr_run <= 1'b0;
  endtask : timer_sync

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    aresetn <= 1'b1;
    reset_and_map();
    result_mirror();
    pin_override();
    input_routes();
    edge_flags();
    set_wins();
    timer_sync();
    tally_and_finish();
  end

  initial begin
    cyc(20000);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_analog_comparator_control
